/* radio_irq_pkg.sv */
package radio_irq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte addresses (low two bits not decoded)
  localparam logic [31:0] CORE_CAPABILITIES_ADDR = 32'h4000_0008;
  localparam logic [31:0] INTERRUPT_MASK_CONTROL_ADDR = 32'h4000_000c;
  localparam logic [31:0] MASKED_INTERRUPT_STATUS_ADDR = 32'h4000_0010;
  localparam logic [31:0] RAW_INTERRUPT_STATUS_ADDR = 32'h4000_0014;
  localparam logic [31:0] IRQ_ACKNOWLEDGE_REGISTER_ADDR = 32'h4000_0018;
  localparam logic [31:0] SOFT_IRQ_CONTROL_ADDR = 32'h4000_0020;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt sources
  localparam int NUM_SOURCES = 10;
  localparam int TICK_BIT = 0;
  localparam int RECEIVE_BIT = 1;
  localparam int SLEEP_END_BIT = 2;
  localparam int EVENT_END_BIT = 3;
  localparam int CIPHER_BIT = 4;
  localparam int FAULT_BIT = 5;
  localparam int COARSE_TIMER_BIT = 6;
  localparam int FINE_TIMER_BIT = 7;
  localparam int EVENT_ABORT_BIT = 8;
  localparam int SOFT_BIT = 9;
  localparam int TICK_IN_EVENT_BIT = 15;
  localparam int SOFT_REQUEST_BIT = 28;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [9:0] MASK_RESET = 10'h11f;
  localparam logic TICK_IN_EVENT_RESET = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // capability fields
  localparam int BUS_WIDTH_POS = 0;
  localparam int CIPHER_UNIT_POS = 1;
  localparam int DIAG_PORT_POS = 2;
  localparam int COEXISTENCE_POS = 3;
  localparam int LEVEL_IRQ_POS = 4;
  localparam int DUAL_MODE_POS = 5;
  localparam int PRESENT_A_POS = 6;
  localparam int CLOCK_MHZ_POS = 8;
  localparam int RADIO_IF_POS = 16;
  localparam int ADDRESS_WIDTH_POS = 24;
  localparam logic [5:0] CLOCK_MHZ_RESET = 6'h00;
  localparam logic [6:0] RADIO_IF_RESET = 7'h02;
  localparam logic [5:0] ADDRESS_WIDTH_RESET = 6'h0f;

  ////////////////////////////////////////////////////////////////////////////
  // ahb transfer type
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage

/* radio_core_irq_mask_status.sv */
`timescale 1ns/100ps

// Contract
// - level interrupts, capability bit 4 reads 1
// - capability bit 0 reads 1, 32-bit bus
// - capability bit 1 reads 1, cipher present
// - capability bit 2 reads 1, diag port
// - capability bit 3 reads 1, coexistence present
// - capability bits 5 and 6 read 0
// - capability 13:8 frequency, resets to 0
// - capability 29:24 reads address width 0xf
// - only unmasked sources raise an interrupt
// - mask reset values per source
// - mask bit 15 gates tick during events
// - mask bits 14:10 read as zero
// - status is raw pending and mask set
// - status bit 0 base tick pending
// - status bit 1 receive, bit 2 sleep
// - status bit 8 abort, bit 3 event end
// - status bit 9 software interrupt pending
// - acknowledge write 1 clears raw, reads 0
// - raw pending flag kept per source
// - soft request raises soft interrupt, self-clears
module radio_core_irq_mask_status #(
  parameter logic [5:0] CLOCK_MHZ = radio_irq_pkg::CLOCK_MHZ_RESET
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [9:0] irqEvent,
  input wire logic inEvent,
  output logic coreIrq
);

  typedef struct packed {
    logic wrPend;
    logic [31:0] wrAddr;
    logic [9:0] mask;
    logic tickInEventEnable;
    logic [9:0] rawPending;
    logic softRequest;
    logic [5:0] clockMhz;
    logic [31:0] rdata;
    logic irq;
  } state_t;

  state_t cur;
  state_t nxt;
  logic [1:0] rstSync;
  logic rstSyncB;
  logic [9:0] eventSync1;
  logic [9:0] eventSync2;
  logic inEventSync1;
  logic inEventSync2;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  function automatic logic hit(input logic [31:0] a, input logic [31:0] reg_addr);
    hit = (a[31:2] == reg_addr[31:2]);
  endfunction

  function automatic logic [31:0] capabilities(input logic [5:0] mhz);
    logic [31:0] c;
    c = 32'h0000_0000;
    c[radio_irq_pkg::BUS_WIDTH_POS] = 1'b1;
    c[radio_irq_pkg::CIPHER_UNIT_POS] = 1'b1;
    c[radio_irq_pkg::DIAG_PORT_POS] = 1'b1;
    c[radio_irq_pkg::COEXISTENCE_POS] = 1'b1;
    c[radio_irq_pkg::LEVEL_IRQ_POS] = 1'b1;
    c[radio_irq_pkg::DUAL_MODE_POS] = 1'b0;
    c[radio_irq_pkg::PRESENT_A_POS] = 1'b0;
    c[radio_irq_pkg::CLOCK_MHZ_POS +: 6] = mhz;
    c[radio_irq_pkg::RADIO_IF_POS +: 7] = radio_irq_pkg::RADIO_IF_RESET;
    c[radio_irq_pkg::ADDRESS_WIDTH_POS +: 6] = radio_irq_pkg::ADDRESS_WIDTH_RESET;
    capabilities = c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // reset release and input synchronisers
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rstSync <= 2'h0;
    end
    else
    begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end

  assign rstSyncB = rstSync[1];

  always_ff @(posedge core_clk or negedge rstSyncB)
  begin
    if (!rstSyncB)
    begin
      eventSync1 <= 10'h000;
      eventSync2 <= 10'h000;
      inEventSync1 <= 1'b0;
      inEventSync2 <= 1'b0;
    end
    else
    begin
      eventSync1 <= irqEvent;
      eventSync2 <= eventSync1;
      inEventSync1 <= inEvent;
      inEventSync2 <= inEventSync1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    logic addrTake;
    logic wrNow;
    logic [9:0] ack;
    logic [9:0] setEvent;
    logic [9:0] masked;
    logic [31:0] rd;
    addrTake = 1'b0;
    wrNow = 1'b0;
    ack = 10'h000;
    setEvent = 10'h000;
    masked = 10'h000;
    rd = 32'h0000_0000;
    nxt = cur;
    nxt.softRequest = 1'b0;
    nxt.clockMhz = CLOCK_MHZ;

    // write data phase
    wrNow = cur.wrPend;
    if (wrNow)
    begin
      if (hit(cur.wrAddr, radio_irq_pkg::INTERRUPT_MASK_CONTROL_ADDR))
      begin
        nxt.mask = hwdata[9:0];
        nxt.tickInEventEnable = hwdata[radio_irq_pkg::TICK_IN_EVENT_BIT];
      end
      if (hit(cur.wrAddr, radio_irq_pkg::IRQ_ACKNOWLEDGE_REGISTER_ADDR))
      begin
        ack = hwdata[9:0];
      end
      if (hit(cur.wrAddr, radio_irq_pkg::SOFT_IRQ_CONTROL_ADDR))
      begin
        nxt.softRequest = hwdata[radio_irq_pkg::SOFT_REQUEST_BIT];
      end
    end

    // raw pending: set wins over acknowledge
    setEvent = eventSync2;
    setEvent[radio_irq_pkg::SOFT_BIT] = cur.softRequest | eventSync2[radio_irq_pkg::SOFT_BIT];
    if (inEventSync2 && !cur.tickInEventEnable)
    begin
      setEvent[radio_irq_pkg::TICK_BIT] = 1'b0;
    end
    nxt.rawPending = (cur.rawPending & ~ack) | setEvent;

    masked = nxt.rawPending & nxt.mask;
    nxt.irq = |masked;

    // address phase
    addrTake = hsel && hready && (htrans == radio_irq_pkg::HTRANS_NONSEQ);
    nxt.wrPend = addrTake && hwrite;
    nxt.wrAddr = haddr;
    if (addrTake && !hwrite)
    begin
      if (hit(haddr, radio_irq_pkg::CORE_CAPABILITIES_ADDR))
      begin
        rd = capabilities(cur.clockMhz);
      end
      else if (hit(haddr, radio_irq_pkg::INTERRUPT_MASK_CONTROL_ADDR))
      begin
        rd[9:0] = cur.mask;
        rd[radio_irq_pkg::TICK_IN_EVENT_BIT] = cur.tickInEventEnable;
      end
      else if (hit(haddr, radio_irq_pkg::MASKED_INTERRUPT_STATUS_ADDR))
      begin
        rd[9:0] = cur.rawPending & cur.mask;
      end
      else if (hit(haddr, radio_irq_pkg::RAW_INTERRUPT_STATUS_ADDR))
      begin
        rd[9:0] = cur.rawPending;
      end
      else
      begin
        rd = 32'h0000_0000;
      end
    end
    nxt.rdata = rd;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge core_clk or negedge rstSyncB)
  begin
    if (!rstSyncB)
    begin
      cur.wrPend <= 1'b0;
      cur.wrAddr <= 32'h0000_0000;
      cur.mask <= radio_irq_pkg::MASK_RESET;
      cur.tickInEventEnable <= radio_irq_pkg::TICK_IN_EVENT_RESET;
      cur.rawPending <= 10'h000;
      cur.softRequest <= 1'b0;
      cur.clockMhz <= radio_irq_pkg::CLOCK_MHZ_RESET;
      cur.rdata <= 32'h0000_0000;
      cur.irq <= 1'b0;
    end
    else
    begin
      cur <= nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  always_ff @(posedge core_clk or negedge rstSyncB)
  begin
    if (!rstSyncB)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign hrdata = cur.rdata;
  assign coreIrq = cur.irq;

endmodule

/* radio_irq_properties.sv */
`timescale 1ns/100ps
module irq_props #(
  parameter logic [5:0] CLOCK_MHZ = 6'h00
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [9:0] irqEvent,
  input wire logic coreIrq
);
  logic take;
  logic [31:0] rdA;
  logic [2:0] age;
  assign take = hsel && hready && htrans == 2'h2;
  ////////////////////////////////////////////////////////////////////////////
  // read address in data phase, cycles since last write
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      rdA <= 32'h0;
      age <= 3'h0;
    end
    else
    begin
      rdA <= (take && !hwrite) ? haddr : 32'h0;
      age <= (take && hwrite) ? 3'h0 : age + {2'h0, age != 3'h7};
    end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  a_cap_flags: assert property (rdA == 32'h4000_0008 |-> hrdata[7:0] == 8'h1f)
    else $error("capability flags wrong");
  a_cap_freq: assert property (rdA == 32'h4000_0008 |-> hrdata[15:8] == {2'h0, CLOCK_MHZ})
    else $error("capability frequency wrong");
  a_cap_width: assert property (rdA == 32'h4000_0008 |-> hrdata[31:24] == 8'h0f)
    else $error("capability width wrong");
  a_mask_rsvd: assert property (rdA == 32'h4000_000c |-> hrdata[14:10] == 5'h0)
    else $error("mask reserved bits set");
  a_stat_upper: assert property (rdA == 32'h4000_0010 |-> hrdata[31:10] == 22'h0)
    else $error("status upper bits set");
  a_ack_zero: assert property (rdA == 32'h4000_0018 |-> hrdata == 32'h0)
    else $error("acknowledge reads nonzero");
  a_irq_hold: assert property (coreIrq && age == 3'h7 && !take |=> coreIrq)
    else $error("interrupt dropped without acknowledge");
  a_irq_cause: assert property ($rose(coreIrq) && age == 3'h7 |-> $past(irqEvent, 3) != 10'h0)
    else $error("interrupt without source event");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or error");
  c_irq: cover property ($rose(coreIrq));
  c_cap: cover property (rdA == 32'h4000_0008);
  c_ack: cover property (rdA == 32'h4000_0018);
endmodule

/* tb.sv */
`timescale 1ns/100ps
module tb;
  localparam logic [31:0] MSK = radio_irq_pkg::INTERRUPT_MASK_CONTROL_ADDR;
  localparam logic [31:0] STA = radio_irq_pkg::MASKED_INTERRUPT_STATUS_ADDR;
  localparam logic [31:0] RAW = radio_irq_pkg::RAW_INTERRUPT_STATUS_ADDR;
  localparam logic [31:0] ACK = radio_irq_pkg::IRQ_ACKNOWLEDGE_REGISTER_ADDR;
  localparam logic [31:0] CAP = radio_irq_pkg::CORE_CAPABILITIES_ADDR;
  localparam logic [31:0] SFT = radio_irq_pkg::SOFT_IRQ_CONTROL_ADDR;
  logic core_clk = 0, rst_b = 0, hsel = 0, hwrite = 0, inEvent = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = '0;
  logic [9:0] irqEvent = '0;
  logic hreadyout, hresp, coreIrq, hready;
  int errors = 0, n_compared = 0, mask, raw, r;
  assign hready = hreadyout;
  always #20 core_clk = ~core_clk;
  radio_core_irq_mask_status dut (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .irqEvent(irqEvent), .inEvent(inEvent), .coreIrq(coreIrq));
  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wready();
    for (int k = 0; k < 20; k++)
    begin
      @(posedge core_clk);
      if (hreadyout === 1'b1)
      begin
        rd = hrdata;
        return;
      end
    end
    errors++;
    finish_test();
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= radio_irq_pkg::HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    wready();
    htrans <= 2'h0;
    hwdata <= d;
    wready();
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task automatic pulse(input int i);
    repeat (4) @(posedge core_clk);
    irqEvent <= 10'h1 << i;
    @(posedge core_clk);
    irqEvent <= '0;
    repeat (4) @(posedge core_clk);
  endtask
  initial
  begin
    void'($urandom(80));
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    rdc(MSK, 32'h811f);
    bus(1'b1, CAP, 32'hffff_ffff);
    bus(1'b1, STA, 32'hffff_ffff);
    rdc(CAP, 32'h0f02001f);
    rdc(STA, 32'h0);
    rdc(32'h4000_0030, 32'h0);
    for (int i = 0; i < 10; i++)
    begin
      r = $urandom();
      bus(1'b1, MSK, r);
      mask = r & 32'h83ff;
      rdc(MSK, mask);
      pulse(i);
      raw = 1 << i;
      @(negedge core_clk);
      check(coreIrq, (raw & mask) != 0);
      @(posedge core_clk);
      rdc(STA, raw & mask);
      rdc(RAW, raw);
      bus(1'b1, ACK, raw);
      rdc(RAW, 32'h0);
      rdc(ACK, 32'h0);
    end
    bus(1'b1, MSK, 32'h200);
    bus(1'b1, SFT, 32'h1 << radio_irq_pkg::SOFT_REQUEST_BIT);
    @(posedge core_clk);
    rdc(STA, 32'h200);
    rdc(SFT, 32'h0);
    bus(1'b1, ACK, 32'h200);
    rdc(RAW, 32'h0);
    bus(1'b1, MSK, 32'h1);
    inEvent <= 1'b1;
    pulse(0);
    rdc(RAW, 32'h0);
    bus(1'b1, MSK, 32'h8001);
    pulse(0);
    rdc(STA, 32'h1);
    inEvent <= 1'b0;
    bus(1'b1, ACK, 32'h1);
    rdc(STA, 32'h0);
    finish_test();
  end
endmodule
bind radio_core_irq_mask_status irq_props #(.CLOCK_MHZ(CLOCK_MHZ)) props (.core_clk(core_clk),
  .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .irqEvent(irqEvent), .coreIrq(coreIrq));
